// ===== design/tcp_pkg.sv
package tcp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h4;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_CS_LSB = 0;
  localparam int CTRL_WGM_LSB = 3;
  localparam int CTRL_COM_LSB = 5;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'h0,
    WGM_PHASE_PWM = 2'h1,
    WGM_CLEAR_ON_MATCH = 2'h2,
    WGM_FAST_PWM = 2'h3
  } tcp_wgm_e;

  typedef enum logic [1:0] {
    COM_NONE = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_CLEAR = 2'h2,
    COM_SET = 2'h3
  } tcp_com_e;

  // One-bit count direction
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } tcp_dir_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcp_bus_req_s;

  typedef struct packed {
    tcp_com_e output_action_select;
    tcp_wgm_e waveform_mode_select;
    logic [2:0] clock_source_select;
  } tcp_ctrl_s;

endpackage

// ===== design/tcp_timer_compare.sv
`timescale 1ns/1ps
`default_nettype none

module tcp_timer_compare (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire tcp_pkg::tcp_bus_req_s bus_req_i,
  input wire logic ext_tick_i,
  input wire logic compare_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  input wire logic port_out_i,
  input wire logic output_pin_direction_bit_i,
  output logic [7:0] rd_data_o,
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic compare_output_state_o,
  output logic oc_pin_o,
  output logic oc_pin_oe_o
);
  import tcp_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  tcp_ctrl_s ctrl;
  logic [7:0] timer_count;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic compare_match_flag;
  logic overflow_flag;
  logic match_pending;
  logic match_blocked;
  tcp_dir_e dir;

  logic [7:0] next_count;
  tcp_dir_e next_dir;
  logic next_oc;
  logic next_cmf;
  logic next_ovf;
  logic tick;
  logic pwm_mode;
  logic match;
  logic match_eff;
  logic count_wr;
  logic compare_wr;
  logic force_hit;
  logic at_max;
  logic ovf_event;
  logic oc_override;

  function automatic logic apply_action(input tcp_com_e com, input logic cur);
    case (com)
      COM_TOGGLE: apply_action = ~cur;
      COM_CLEAR: apply_action = 1'b0;
      COM_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  function automatic logic bus_hit(input tcp_bus_req_s req, input logic [2:0] addr);
    bus_hit = req.wr && (req.addr == addr);
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  assign pwm_mode = (ctrl.waveform_mode_select == WGM_FAST_PWM) ||
                    (ctrl.waveform_mode_select == WGM_PHASE_PWM);
  assign count_wr = bus_hit(bus_req_i, ADDR_COUNT);
  assign compare_wr = bus_hit(bus_req_i, ADDR_COMPARE);
  assign force_hit = bus_hit(bus_req_i, ADDR_CTRL) && bus_req_i.wdata[CTRL_FORCE_BIT] && !pwm_mode;
  assign match = (timer_count == compare_value);
  assign match_eff = tick && match && !match_blocked;
  assign at_max = (timer_count == COUNT_MAX);
  assign oc_override = (ctrl.output_action_select != COM_NONE);

  always_comb begin
    if (ctrl.clock_source_select == CS_STOPPED) begin
      tick = 1'b0;
    end else if (ctrl.clock_source_select == CS_DIRECT) begin
      tick = 1'b1;
    end else begin
      tick = ext_tick_i;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  always_comb begin
    next_count = timer_count;
    next_dir = dir;
    if (count_wr) begin
      next_count = bus_req_i.wdata;
    end else if (tick) begin
      case (ctrl.waveform_mode_select)
        WGM_CLEAR_ON_MATCH: begin
          if (match_eff) begin
            next_count = COUNT_BOTTOM;
          end else begin
            next_count = timer_count + COUNT_STEP;
          end
        end
        WGM_PHASE_PWM: begin
          if (dir == DIR_UP) begin
            if (at_max) begin
              next_dir = DIR_DOWN;
              next_count = timer_count - COUNT_STEP;
            end else begin
              next_count = timer_count + COUNT_STEP;
            end
          end else begin
            if (timer_count == COUNT_BOTTOM) begin
              next_dir = DIR_UP;
              next_count = timer_count + COUNT_STEP;
            end else begin
              next_count = timer_count - COUNT_STEP;
            end
          end
        end
        default: next_count = timer_count + COUNT_STEP;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_count <= COUNT_BOTTOM;
      dir <= DIR_UP;
    end else begin
      timer_count <= next_count;
      dir <= next_dir;
    end
  end

  // ************************************************************
  // Match blocking and delayed flag
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      match_blocked <= 1'b0;
    end else if (count_wr) begin
      match_blocked <= 1'b1;
    end else if (tick) begin
      match_blocked <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      match_pending <= 1'b0;
    end else if (tick) begin
      match_pending <= match_eff;
    end
  end

  // ************************************************************
  // Compare register and buffer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_buffer <= DATA_ZERO;
    end else if (compare_wr) begin
      compare_buffer <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_value <= DATA_ZERO;
    end else if (!pwm_mode) begin
      if (compare_wr) begin
        compare_value <= bus_req_i.wdata;
      end
    end else if (tick && at_max) begin
      compare_value <= compare_buffer;
    end
  end

  // ************************************************************
  // Flags
  // ************************************************************
  always_comb begin
    case (ctrl.waveform_mode_select)
      WGM_FAST_PWM: ovf_event = tick && at_max;
      WGM_PHASE_PWM: ovf_event = tick && (dir == DIR_DOWN) && (timer_count == COUNT_BOTTOM);
      default: ovf_event = tick && at_max && !count_wr;
    endcase
  end

  always_comb begin
    next_cmf = compare_match_flag;
    if (bus_hit(bus_req_i, ADDR_FLAGS) && bus_req_i.wdata[FLAG_CMP_BIT]) begin
      next_cmf = 1'b0;
    end
    if (compare_irq_ack_i) begin
      next_cmf = 1'b0;
    end
    if (tick && match_pending) begin
      next_cmf = 1'b1;
    end
  end

  always_comb begin
    next_ovf = overflow_flag;
    if (bus_hit(bus_req_i, ADDR_FLAGS) && bus_req_i.wdata[FLAG_OVF_BIT]) begin
      next_ovf = 1'b0;
    end
    if (overflow_irq_ack_i) begin
      next_ovf = 1'b0;
    end
    if (ovf_event) begin
      next_ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      compare_irq_o <= 1'b0;
      overflow_irq_o <= 1'b0;
    end else begin
      compare_match_flag <= next_cmf;
      overflow_flag <= next_ovf;
      compare_irq_o <= next_cmf && compare_irq_enable;
      overflow_irq_o <= next_ovf && overflow_irq_enable;
    end
  end

  // ************************************************************
  // Waveform output state
  // ************************************************************
  always_comb begin
    next_oc = compare_output_state_o;
    if (force_hit) begin
      next_oc = apply_action(tcp_com_e'(bus_req_i.wdata[CTRL_COM_LSB +: 2]), compare_output_state_o);
    end else if (tick) begin
      case (ctrl.waveform_mode_select)
        WGM_FAST_PWM: begin
          if (match_eff) begin
            next_oc = apply_action(ctrl.output_action_select, compare_output_state_o);
          end else if (at_max && ctrl.output_action_select != COM_TOGGLE) begin
            next_oc = apply_action(ctrl.output_action_select, compare_output_state_o) ^ oc_override;
          end
        end
        WGM_PHASE_PWM: begin
          if (match_eff && ctrl.output_action_select != COM_TOGGLE) begin
            next_oc = apply_action(ctrl.output_action_select, compare_output_state_o) ^
                      (dir == DIR_DOWN && oc_override);
          end
        end
        default: begin
          if (match_eff) begin
            next_oc = apply_action(ctrl.output_action_select, compare_output_state_o);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_output_state_o <= 1'b0;
      oc_pin_o <= 1'b0;
      oc_pin_oe_o <= 1'b0;
    end else begin
      compare_output_state_o <= next_oc;
      oc_pin_o <= oc_override ? next_oc : port_out_i;
      oc_pin_oe_o <= output_pin_direction_bit_i;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl <= '{COM_NONE, WGM_NORMAL, CS_STOPPED};
    end else if (bus_hit(bus_req_i, ADDR_CTRL)) begin
      ctrl.clock_source_select <= bus_req_i.wdata[CTRL_CS_LSB +: 3];
      ctrl.waveform_mode_select <= tcp_wgm_e'(bus_req_i.wdata[CTRL_WGM_LSB +: 2]);
      ctrl.output_action_select <= tcp_com_e'(bus_req_i.wdata[CTRL_COM_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      compare_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (bus_hit(bus_req_i, ADDR_IRQ_EN)) begin
      compare_irq_enable <= bus_req_i.wdata[FLAG_CMP_BIT];
      overflow_irq_enable <= bus_req_i.wdata[FLAG_OVF_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= DATA_ZERO;
    end else if (!bus_req_i.rd) begin
      rd_data_o <= DATA_ZERO;
    end else if (bus_req_i.addr == ADDR_CTRL) begin
      rd_data_o <= {1'b0, ctrl.output_action_select, ctrl.waveform_mode_select,
                    ctrl.clock_source_select};
    end else if (bus_req_i.addr == ADDR_COUNT) begin
      rd_data_o <= timer_count;
    end else if (bus_req_i.addr == ADDR_COMPARE) begin
      rd_data_o <= pwm_mode ? compare_buffer : compare_value;
    end else if (bus_req_i.addr == ADDR_FLAGS) begin
      rd_data_o <= {6'h00, compare_match_flag, overflow_flag};
    end else if (bus_req_i.addr == ADDR_IRQ_EN) begin
      rd_data_o <= {6'h00, compare_irq_enable, overflow_irq_enable};
    end else begin
      rd_data_o <= DATA_ZERO;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_match_latch: assert property (
    match_eff |=> match_pending)
    else $error("match not remembered for the next tick");
  a_flag_one_late: assert property (
    tick && match_pending |=> compare_match_flag)
    else $error("match flag not set on tick after match");
  a_flag_not_same: assert property (
    !compare_match_flag && tick && match_eff && !match_pending |=> !compare_match_flag)
    else $error("match flag set in match cycle");
  a_flag_w1c: assert property (
    compare_match_flag && !compare_irq_ack_i && bus_hit(bus_req_i, ADDR_FLAGS) && !bus_req_i.wdata[FLAG_CMP_BIT] |=>
      compare_match_flag)
    else $error("writing zero cleared the flag");
  a_block_arm: assert property (
    count_wr |=> match_blocked)
    else $error("count write did not arm match blocking");
  a_write_blocks: assert property (
    tick && match_blocked |=> !match_pending)
    else $error("match seen after count write");
  a_count_prio: assert property (
    count_wr |=> timer_count == $past(bus_req_i.wdata))
    else $error("count write lost");
  a_normal_wrap: assert property (
    ctrl.waveform_mode_select == WGM_NORMAL && tick && at_max && !count_wr |=>
      timer_count == COUNT_BOTTOM && overflow_flag)
    else $error("normal mode wrap or overflow wrong");
  a_ctc_clear: assert property (
    ctrl.waveform_mode_select == WGM_CLEAR_ON_MATCH && match_eff && !count_wr |=> timer_count == COUNT_BOTTOM)
    else $error("clear on match failed");
  a_force_noflag: assert property (
    force_hit && !compare_match_flag && !(tick && match_pending) |=> !compare_match_flag)
    else $error("force strobe set the flag");
  a_stop_holds: assert property (
    ctrl.clock_source_select == CS_STOPPED && !count_wr |=> $stable(timer_count))
    else $error("count moved while stopped");
  a_action_none: assert property (
    ctrl.output_action_select == COM_NONE && !force_hit |=> $stable(compare_output_state_o))
    else $error("output changed with no action");

endmodule

`default_nettype wire

// ===== dv/tcp_timer_compare_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tcp_timer_compare_tb;
  import tcp_pkg::*;

  // ************************************************************
  // Clock, reset and design
  // ************************************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  tcp_bus_req_s bus_req_i = '0;
  logic ext_tick_i = 1'b0;
  logic compare_irq_ack_i = 1'b0;
  logic overflow_irq_ack_i = 1'b0;
  logic port_out_i = 1'b0;
  logic output_pin_direction_bit_i = 1'b0;
  logic [7:0] rd_data_o;
  logic compare_irq_o;
  logic overflow_irq_o;
  logic compare_output_state_o;
  logic oc_pin_o;
  logic oc_pin_oe_o;
  int mismatches = 0;
  int samples_checked = 0;

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  tcp_timer_compare tcp_timer_compare_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .bus_req_i(bus_req_i),
    .ext_tick_i(ext_tick_i),
    .compare_irq_ack_i(compare_irq_ack_i),
    .overflow_irq_ack_i(overflow_irq_ack_i),
    .port_out_i(port_out_i),
    .output_pin_direction_bit_i(output_pin_direction_bit_i),
    .rd_data_o(rd_data_o),
    .compare_irq_o(compare_irq_o),
    .overflow_irq_o(overflow_irq_o),
    .compare_output_state_o(compare_output_state_o),
    .oc_pin_o(oc_pin_o),
    .oc_pin_oe_o(oc_pin_oe_o)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_req_i <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: DATA_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_req_i <= '0;
    #1;
    check8(rd_data_o, exp);
  endtask

  // n timer ticks from the outside prescaler, each one then let settle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_tick_i <= 1'b1;
      @(posedge clk_i);
      ext_tick_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rd_chk(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_COUNT, 8'h00);
    rd_chk(ADDR_COMPARE, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_IRQ_EN, 8'h00);
    rd_chk(3'h5, 8'h00);
    check1(compare_output_state_o, 1'b0);
    check1(oc_pin_oe_o, 1'b0);
  endtask

  task automatic t_normal_overflow;
    bus_wr(ADDR_COMPARE, 8'h80);
    bus_wr(ADDR_COUNT, 8'hFE);
    bus_wr(ADDR_CTRL, 8'h02);
    ticks(1);
    rd_chk(ADDR_FLAGS, 8'h00);
    ticks(1);
    rd_chk(ADDR_COUNT, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h01);
    bus_wr(ADDR_IRQ_EN, 8'h01);
    wait_cycles(2);
    check1(overflow_irq_o, 1'b1);
    @(posedge clk_i);
    overflow_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    overflow_irq_ack_i <= 1'b0;
    wait_cycles(2);
    check1(overflow_irq_o, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h00);
    bus_wr(ADDR_IRQ_EN, 8'h00);
  endtask

  task automatic t_match_flag;
    bus_wr(ADDR_COMPARE, 8'h10);
    bus_wr(ADDR_COUNT, 8'h0E);
    ticks(3);
    rd_chk(ADDR_FLAGS, 8'h00);
    ticks(1);
    rd_chk(ADDR_FLAGS, 8'h02);
    bus_wr(ADDR_IRQ_EN, 8'h02);
    wait_cycles(2);
    check1(compare_irq_o, 1'b1);
    bus_wr(ADDR_FLAGS, 8'h01);
    rd_chk(ADDR_FLAGS, 8'h02);
    bus_wr(ADDR_FLAGS, 8'h02);
    wait_cycles(2);
    check1(compare_irq_o, 1'b0);
    rd_chk(ADDR_FLAGS, 8'h00);
    bus_wr(ADDR_IRQ_EN, 8'h00);
  endtask

  // Count written while stopped still hides the first match
  task automatic t_block;
    bus_wr(ADDR_CTRL, 8'h00);
    bus_wr(ADDR_COMPARE, 8'h20);
    bus_wr(ADDR_COUNT, 8'h20);
    rd_chk(ADDR_COUNT, 8'h20);
    bus_wr(ADDR_CTRL, 8'h02);
    ticks(3);
    rd_chk(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_COUNT, 8'h23);
  endtask

  task automatic t_ctc_toggle;
    bus_wr(ADDR_CTRL, 8'h00);
    bus_wr(ADDR_COMPARE, 8'h03);
    bus_wr(ADDR_COUNT, 8'h00);
    bus_wr(ADDR_CTRL, 8'hC0);
    @(posedge clk_i);
    output_pin_direction_bit_i <= 1'b1;
    bus_wr(ADDR_CTRL, 8'h32);
    ticks(3);
    check1(compare_output_state_o, 1'b0);
    ticks(1);
    rd_chk(ADDR_COUNT, 8'h00);
    check1(compare_output_state_o, 1'b1);
    check1(oc_pin_o, 1'b1);
    check1(oc_pin_oe_o, 1'b1);
    ticks(4);
    check1(compare_output_state_o, 1'b0);
    ticks(4);
    check1(compare_output_state_o, 1'b1);
    bus_wr(ADDR_CTRL, 8'h12);
    wait_cycles(2);
    check1(oc_pin_o, 1'b0);
    ticks(4);
    check1(compare_output_state_o, 1'b1);
    bus_wr(ADDR_CTRL, 8'h38);
    wait_cycles(2);
    check1(oc_pin_o, 1'b1);
    bus_wr(ADDR_CTRL, 8'h30);
    wait_cycles(1);
    check1(compare_output_state_o, 1'b1);
  endtask

  task automatic t_force;
    bus_wr(ADDR_CTRL, 8'h00);
    bus_wr(ADDR_COUNT, 8'h55);
    bus_wr(ADDR_FLAGS, 8'h03);
    bus_wr(ADDR_CTRL, 8'hC0);
    wait_cycles(1);
    check1(compare_output_state_o, 1'b0);
    rd_chk(ADDR_CTRL, 8'h40);
    rd_chk(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_COUNT, 8'h55);
    bus_wr(ADDR_CTRL, 8'hE0);
    wait_cycles(1);
    check1(compare_output_state_o, 1'b1);
    bus_wr(ADDR_CTRL, 8'hA0);
    wait_cycles(1);
    check1(compare_output_state_o, 1'b0);
    bus_wr(ADDR_CTRL, 8'h18);
    bus_wr(ADDR_CTRL, 8'hB8);
    wait_cycles(1);
    check1(compare_output_state_o, 1'b0);
  endtask

  // Old active value still matches while the buffer holds a new one
  task automatic t_pwm_buffer;
    bus_wr(ADDR_CTRL, 8'h00);
    bus_wr(ADDR_COMPARE, 8'h40);
    bus_wr(ADDR_CTRL, 8'h1A);
    bus_wr(ADDR_COMPARE, 8'h50);
    rd_chk(ADDR_COMPARE, 8'h50);
    bus_wr(ADDR_FLAGS, 8'h03);
    bus_wr(ADDR_COUNT, 8'h3F);
    ticks(3);
    rd_chk(ADDR_FLAGS, 8'h02);
    @(posedge clk_i);
    compare_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    compare_irq_ack_i <= 1'b0;
    rd_chk(ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_ctc_wrap;
    bus_wr(ADDR_CTRL, 8'h00);
    bus_wr(ADDR_COUNT, 8'h20);
    bus_wr(ADDR_CTRL, 8'h12);
    bus_wr(ADDR_FLAGS, 8'h03);
    bus_wr(ADDR_COMPARE, 8'h05);
    ticks(8'hDF);
    rd_chk(ADDR_FLAGS, 8'h00);
    ticks(1);
    rd_chk(ADDR_COUNT, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h01);
  endtask

  // Port value on the pin, direct clocking, then the dual-slope count
  task automatic t_modes;
    bus_wr(ADDR_CTRL, 8'h00);
    port_out_i <= 1'b1;
    wait_cycles(2);
    check1(oc_pin_o, 1'b1);
    bus_wr(ADDR_COUNT, 8'h10);
    bus_wr(ADDR_CTRL, 8'h01);
    bus_wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_COUNT, 8'h12);
    bus_wr(ADDR_COUNT, 8'hFE);
    bus_wr(ADDR_CTRL, 8'h0A);
    ticks(2);
    rd_chk(ADDR_COUNT, 8'hFE);
    bus_wr(ADDR_FLAGS, 8'h03);
    bus_wr(ADDR_COUNT, 8'h01);
    ticks(2);
    rd_chk(ADDR_FLAGS, 8'h01);
    rd_chk(ADDR_COUNT, 8'h01);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_normal_overflow();
    t_match_flag();
    t_block();
    t_ctc_toggle();
    t_force();
    t_pwm_buffer();
    t_ctc_wrap();
    t_modes();
    finish_test();
  end

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

endmodule

`default_nettype wire
